// [lane_sync.sv]
// Two-flop synchroniser for the flash data lanes.
// Assumes the lanes change only on the falling sclk edge the host makes.
`timescale 1ns/100ps
`default_nettype none
module lane_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Lanes
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// [qpi_flash_model.sv]
// Behavioural four-lane serial flash on the far side of the host.
// Assumes lanes are sampled on sclk rise; answers are launched on sclk fall.
`timescale 1ns/100ps
`default_nettype none
module qpi_flash_model #(
  // Identification values are arbitrary
  parameter logic [23:0] JID = 24'h3C_4117,
  parameter logic [7:0] EID = 8'h2B
) (
  // Flash pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io,
  output logic [3:0] drv,
  output logic en
);
  logic [7:0] op = 0, sr_lo = 0, sr_hi = 0, cfg = 0, b0 = 0, b1 = 0, rb;
  logic [23:0] addr = 0;
  logic [3:0] hi = 0;
  logic [1:0] dc = 2'h1;
  logic wel = 0, vw = 0, lock = 0, sleep = 0, armed = 0, rd;
  int n = 0, nb = 0, ds, j;
  assign ds = 2 + (op inside {8'h0B, 8'h0C, 8'hEB, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h36, 8'h39,
    8'h3D, 8'hAB, 8'h90, 8'h5A} ? 6 : 0)
    + (op inside {8'h0B, 8'h0C, 8'hEB, 8'h5A} ? (dc == 0 ? 10 : 2 * dc + 2) : 0);
  assign j = n - ds;
  assign rd = op inside {8'h0B, 8'h0C, 8'hEB, 8'h05, 8'h35, 8'h15, 8'h3D, 8'h9F, 8'h90, 8'hAB,
    8'h5A};
  always_comb begin
    case (op)
      8'h05: rb = {sr_lo[7:2], wel, 1'b0};
      8'h35: rb = sr_hi;
      8'h15: rb = cfg;
      8'h3D: rb = {7'h00, lock};
      8'h9F: rb = 8'(JID >> (16 - 8 * (j / 2)));
      8'h90: rb = (j[1] ^ addr[0]) ? JID[15:8] : JID[23:16];
      8'hAB: rb = EID;
      default: rb = addr[7:0] + 8'(j / 2);
    endcase
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (n < 2) op <= {op[3:0], io};
      else if (n >= ds) begin
        hi <= io;
        if (j[0] && j < 2) b0 <= {hi, io};
        if (j[0] && j >= 2 && j < 4) b1 <= {hi, io};
        if (j[0]) nb <= j / 2 + 1;
      end else if (n < 8) addr <= {addr[19:0], io};
      n <= n + 1;
    end
  end
  // answer launched on fall, high nibble first
  always @(negedge sclk) begin
    if (!cs_n && rd && n >= ds && (!sleep || op == 8'hAB)) begin
      en <= 1'b1;
      drv <= j[0] ? rb[3:0] : rb[7:4];
    end
  end
  initial en = 1'b0;
  always @(posedge cs_n) begin
    en <= 1'b0;
    n <= 0;
    nb <= 0;
    if (!sleep || op == 8'hAB) begin
      if (op inside {8'h01, 8'h31, 8'h11, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7}) wel <= 1'b0;
      vw <= op == 8'h50;
      armed <= op == 8'h66;
      case (op)
        8'h06: wel <= 1'b1;
        8'h04: wel <= 1'b0;
        8'h01: begin
          if (wel || vw) sr_lo <= b0;
          if ((wel || vw) && nb == 2) sr_hi <= b1;
        end
        8'h31: if (wel || vw) sr_hi <= b0;
        8'h11: if (wel || vw) cfg <= b0;
        8'hC0: dc <= b0[5:4];
        8'h7E: lock <= 1'b1;
        8'h98: lock <= 1'b0;
        8'hB9: sleep <= 1'b1;
        8'hAB: sleep <= 1'b0;
        8'h99: if (armed) dc <= 2'h1;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [qpi_host.sv]
// Host controller that drives a serial NOR flash in four-lane command mode.
// Assumes the flash is already in four-lane mode; makes sclk by dividing ref_clk.
`timescale 1ns/100ps
`default_nettype none
module qpi_host #(
  parameter int SCLK_HALF = 2,
  parameter int LEN_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  // Write data
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read data
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Status
  output logic busy,
  output logic quad_active,
  output logic [1:0] read_wrap,
  // Flash pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [3:0] io_in
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END, ST_GAP} state_t;

  function automatic logic op_has_addr(input logic [7:0] op, input logic [LEN_W-1:0] len);
    case (op)
      qpi_host_pkg::OP_FAST_READ, qpi_host_pkg::OP_WRAP_READ, qpi_host_pkg::OP_QUAD_IO_READ,
      qpi_host_pkg::OP_PAGE_PROGRAM, qpi_host_pkg::OP_SECTOR_ERASE,
      qpi_host_pkg::OP_SMALL_BLOCK_ERASE, qpi_host_pkg::OP_LARGE_BLOCK_ERASE,
      qpi_host_pkg::OP_SINGLE_BLOCK_LOCK, qpi_host_pkg::OP_SINGLE_BLOCK_UNLOCK,
      qpi_host_pkg::OP_READ_BLOCK_LOCK, qpi_host_pkg::OP_READ_MAKER_DEV_ID,
      qpi_host_pkg::OP_READ_SFDP: op_has_addr = 1'b1;
      qpi_host_pkg::OP_WAKE_READ_ELEC_ID: op_has_addr = (len != '0);
      default: op_has_addr = 1'b0;
    endcase
  endfunction

  function automatic logic op_uses_dummy(input logic [7:0] op);
    case (op)
      qpi_host_pkg::OP_FAST_READ, qpi_host_pkg::OP_WRAP_READ, qpi_host_pkg::OP_QUAD_IO_READ,
      qpi_host_pkg::OP_READ_SFDP: op_uses_dummy = 1'b1;
      default: op_uses_dummy = 1'b0;
    endcase
  endfunction

  function automatic qpi_host_pkg::dir_t op_dir(input logic [7:0] op,
                                                input logic [LEN_W-1:0] len);
    case (op)
      qpi_host_pkg::OP_PAGE_PROGRAM, qpi_host_pkg::OP_WRITE_STATUS,
      qpi_host_pkg::OP_WRITE_STATUS_HIGH, qpi_host_pkg::OP_WRITE_CONFIG,
      qpi_host_pkg::OP_SET_READ_PARAMS: op_dir = qpi_host_pkg::DIR_WRITE;
      qpi_host_pkg::OP_FAST_READ, qpi_host_pkg::OP_WRAP_READ, qpi_host_pkg::OP_QUAD_IO_READ,
      qpi_host_pkg::OP_READ_BLOCK_LOCK, qpi_host_pkg::OP_READ_STATUS_LOW,
      qpi_host_pkg::OP_READ_STATUS_HIGH, qpi_host_pkg::OP_READ_CONFIG,
      qpi_host_pkg::OP_READ_MAKER_DEV_ID, qpi_host_pkg::OP_READ_STANDARD_ID,
      qpi_host_pkg::OP_READ_SFDP: op_dir = qpi_host_pkg::DIR_READ;
      qpi_host_pkg::OP_WAKE_READ_ELEC_ID:
        op_dir = (len != '0) ? qpi_host_pkg::DIR_READ : qpi_host_pkg::DIR_NONE;
      default: op_dir = qpi_host_pkg::DIR_NONE;
    endcase
  endfunction

  // Data bytes actually carried; commands without data are forced to zero
  function automatic logic [LEN_W-1:0] op_len(input logic [7:0] op,
                                               input logic [LEN_W-1:0] len);
    logic [LEN_W-1:0] one;
    one = LEN_W'(1);
    case (op)
      qpi_host_pkg::OP_WRITE_STATUS:
        op_len = (len == '0) ? one : ((len > LEN_W'(2)) ? LEN_W'(2) : len);
      qpi_host_pkg::OP_WRITE_STATUS_HIGH, qpi_host_pkg::OP_WRITE_CONFIG,
      qpi_host_pkg::OP_SET_READ_PARAMS, qpi_host_pkg::OP_READ_BLOCK_LOCK,
      qpi_host_pkg::OP_READ_STATUS_LOW, qpi_host_pkg::OP_READ_STATUS_HIGH,
      qpi_host_pkg::OP_READ_CONFIG: op_len = one;
      qpi_host_pkg::OP_WAKE_READ_ELEC_ID: op_len = (len == '0) ? '0 : one;
      qpi_host_pkg::OP_READ_STANDARD_ID:
        op_len = (len == '0) ? one : ((len > LEN_W'(3)) ? LEN_W'(3) : len);
      qpi_host_pkg::OP_FAST_READ, qpi_host_pkg::OP_WRAP_READ, qpi_host_pkg::OP_QUAD_IO_READ,
      qpi_host_pkg::OP_PAGE_PROGRAM, qpi_host_pkg::OP_READ_MAKER_DEV_ID,
      qpi_host_pkg::OP_READ_SFDP: op_len = (len == '0) ? one : len;
      default: op_len = '0;
    endcase
  endfunction

  function automatic logic [3:0] dummy_clocks(input logic [1:0] code);
    case (code)
      2'h0: dummy_clocks = qpi_host_pkg::DUMMY_CLOCKS_CODE0;
      2'h1: dummy_clocks = qpi_host_pkg::DUMMY_CLOCKS_CODE1;
      2'h2: dummy_clocks = qpi_host_pkg::DUMMY_CLOCKS_CODE2;
      default: dummy_clocks = qpi_host_pkg::DUMMY_CLOCKS_CODE3;
    endcase
  endfunction

  state_t state;
  qpi_host_pkg::dir_t dir;
  logic [7:0] op;
  logic [31:0] out_sr;
  logic [15:0] nib;
  logic [15:0] addr_end;
  logic [15:0] dum_end;
  logic [15:0] data_end;
  logic [7:0] div;
  logic [3:0] gap;
  logic [7:0] wr_byte;
  logic [3:0] rd_hi;
  logic [1:0] dummy_code;
  logic arm_seen;
  logic [3:0] lane;

  lane_sync #(.WIDTH(4)) u_lane_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(io_in),
    .q(lane)
  );

  // Frame shape worked out when the command is taken
  wire take = (state == ST_IDLE) && cmd_valid && cmd_ready;
  wire qpi_host_pkg::dir_t take_dir = op_dir(cmd_op, cmd_len);
  wire take_has_addr = op_has_addr(cmd_op, cmd_len);
  wire [LEN_W-1:0] take_len = op_len(cmd_op, cmd_len);
  wire [3:0] take_dummy = op_uses_dummy(cmd_op) ? dummy_clocks(dummy_code) : 4'h0;
  wire [15:0] take_addr_end = qpi_host_pkg::OPCODE_NIBBLES +
                              (take_has_addr ? qpi_host_pkg::ADDR_NIBBLES : 16'h0000);
  wire [15:0] take_dum_end = take_addr_end + {12'h000, take_dummy};
  wire [15:0] take_data_end = take_dum_end + 16'({take_len, 1'b0});

  // Position of the nibble just clocked and of the one to launch next
  wire tick = (div == 8'(SCLK_HALF - 1));
  wire [15:0] nx = nib + 16'h0001;
  wire [15:0] nx_rel = nx - dum_end;
  wire [15:0] cur_rel = nib - dum_end;
  wire fall = (state == ST_SHIFT) && tick && sclk;
  wire cur_is_read = (dir == qpi_host_pkg::DIR_READ) && (nib >= dum_end);
  wire last = (nx == data_end);
  wire nx_in_cmd = (nx < addr_end);
  wire nx_in_data = (nx >= dum_end);
  wire nx_write = nx_in_data && (dir == qpi_host_pkg::DIR_WRITE);
  wire reset_pair = arm_seen && (op == qpi_host_pkg::OP_DO_RESET);

  // Divider runs only while a frame is on the pins
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state == ST_IDLE || state == ST_GAP || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      dir <= qpi_host_pkg::DIR_NONE;
      op <= 8'h00;
      out_sr <= 32'h0000_0000;
      nib <= 16'h0000;
      addr_end <= 16'h0000;
      dum_end <= 16'h0000;
      data_end <= 16'h0000;
      gap <= 4'h0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          cmd_ready <= quad_active;
          if (take) begin
            state <= ST_SHIFT;
            cmd_ready <= 1'b0;
            busy <= 1'b1;
            cs_n <= 1'b0;
            io_out <= cmd_op[7:4];
            io_oe <= 4'hF;
            out_sr <= {cmd_op[3:0], take_has_addr ? cmd_addr : 24'h00_0000, 4'h0};
            op <= cmd_op;
            dir <= take_dir;
            nib <= 16'h0000;
            addr_end <= take_addr_end;
            dum_end <= take_dum_end;
            data_end <= take_data_end;
          end
        end
        ST_SHIFT: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
          end else if (tick) begin
            sclk <= 1'b0;
            nib <= nx;
            if (last) begin
              state <= ST_END;
            end else if (nx_in_cmd) begin
              io_out <= out_sr[31:28];
              out_sr <= {out_sr[27:0], 4'h0};
            end else if (nx_write) begin
              io_out <= nx_rel[0] ? wr_byte[3:0] : wr_data[7:4];
            end else begin
              // release lanes for dummy and read data
              io_oe <= 4'h0;
            end
          end
        end
        ST_END: begin
          if (tick) begin
            cs_n <= 1'b1;
            io_oe <= 4'h0;
            gap <= 4'h0;
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          gap <= gap + 4'h1;
          if (gap == qpi_host_pkg::CS_GAP_CYCLES - 4'h1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          cs_n <= 1'b1;
          io_oe <= 4'h0;
        end
      endcase
    end
  end

  // Write bytes: latched at the high nibble, user refills after wr_take
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_byte <= 8'h00;
      wr_take <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      if (fall && !last && !nx_in_cmd && nx_write && !nx_rel[0]) begin
        wr_byte <= wr_data;
        wr_take <= 1'b1;
      end
    end
  end

  // Read bytes: lanes sampled just before each falling edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_hi <= 4'h0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (fall && cur_is_read) begin
        if (!cur_rel[0]) begin
          rd_hi <= lane;
        end else begin
          rd_data <= {rd_hi, lane};
          rd_valid <= 1'b1;
        end
      end
    end
  end

  // Side effects that take hold once a frame is closed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      quad_active <= 1'b1;
      arm_seen <= 1'b0;
      dummy_code <= qpi_host_pkg::DUMMY_CODE_RESET;
      read_wrap <= qpi_host_pkg::WRAP_CODE_RESET;
    end else if (state == ST_END && tick) begin
      arm_seen <= (op == qpi_host_pkg::OP_ARM_RESET);
      if (op == qpi_host_pkg::OP_SET_READ_PARAMS) begin
        // dummy and wrap follow the sent byte
        dummy_code <= wr_byte[qpi_host_pkg::PARAM_DUMMY_LSB +: 2];
        read_wrap <= wr_byte[qpi_host_pkg::PARAM_WRAP_LSB +: 2];
      end
      if (reset_pair) begin
        // flash back at its reset read parameters
        dummy_code <= qpi_host_pkg::DUMMY_CODE_RESET;
        read_wrap <= qpi_host_pkg::WRAP_CODE_RESET;
      end
      if (op == qpi_host_pkg::OP_EXIT_QUAD) begin
        // no more four-lane frames until reset
        quad_active <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [qpi_host_pkg.sv]
// Constants for the four-lane serial flash host controller.
// Assumes a 25 MHz reference clock and a flash already in four-lane command mode.
package qpi_host_pkg;

  // Opcodes sent in four-lane command mode
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SMALL_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_LARGE_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND_WRITE = 8'h75;
  localparam logic [7:0] OP_RESUME_WRITE = 8'h7A;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_VOLATILE_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_SINGLE_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_SINGLE_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_READ_BLOCK_LOCK = 8'h3D;
  localparam logic [7:0] OP_LOCK_ALL_BLOCKS = 8'h7E;
  localparam logic [7:0] OP_UNLOCK_ALL_BLOCKS = 8'h98;
  localparam logic [7:0] OP_READ_STATUS_LOW = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HIGH = 8'h35;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS_HIGH = 8'h31;
  localparam logic [7:0] OP_WRITE_CONFIG = 8'h11;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_READ_ELEC_ID = 8'hAB;
  localparam logic [7:0] OP_SET_READ_PARAMS = 8'hC0;
  localparam logic [7:0] OP_READ_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_READ_STANDARD_ID = 8'h9F;
  localparam logic [7:0] OP_READ_SFDP = 8'h5A;
  localparam logic [7:0] OP_EXIT_QUAD = 8'hFF;
  localparam logic [7:0] OP_ARM_RESET = 8'h66;
  localparam logic [7:0] OP_DO_RESET = 8'h99;

  // Frame shape, in nibbles (one sclk period each)
  localparam logic [15:0] OPCODE_NIBBLES = 16'h0002;
  localparam logic [15:0] ADDR_NIBBLES = 16'h0006;

  // Read parameter byte layout and dummy clocks per code
  localparam int PARAM_DUMMY_LSB = 4;
  localparam int PARAM_WRAP_LSB = 0;
  localparam logic [1:0] DUMMY_CODE_RESET = 2'h1;
  localparam logic [1:0] WRAP_CODE_RESET = 2'h0;
  localparam logic [3:0] DUMMY_CLOCKS_CODE0 = 4'hA;
  localparam logic [3:0] DUMMY_CLOCKS_CODE1 = 4'h4;
  localparam logic [3:0] DUMMY_CLOCKS_CODE2 = 4'h6;
  localparam logic [3:0] DUMMY_CLOCKS_CODE3 = 4'h8;

  // Timing
  localparam int REF_CLK_NS = 40;
  localparam int CS_GAP_NS = 80;
  localparam logic [3:0] CS_GAP_CYCLES = 4'((CS_GAP_NS + REF_CLK_NS - 1) / REF_CLK_NS);

  typedef enum logic [1:0] {DIR_NONE, DIR_WRITE, DIR_READ} dir_t;

endpackage

// [qpi_host_props.sv]
// Port assertions for the four-lane flash host.
// Assumes one ref_clk domain; bound into every qpi_host instance.
`timescale 1ns/100ps
`default_nettype none
module qpi_host_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic wr_take,
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic quad_active,
  // Flash pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_take;
    cmd_valid && cmd_ready |=> !cs_n && busy && io_oe == 4'hF && io_out == $past(cmd_op[7:4]);
  endproperty
  property p_idle;
    cs_n |-> !sclk;
  endproperty
  property p_lanes;
    !cs_n && $past(!cs_n) && io_oe == 4'hF && $past(io_oe) == 4'hF && !$fell(sclk)
      |-> $stable(io_out);
  endproperty
  property p_rd;
    rd_valid |-> busy && io_oe == 4'h0 ##1 !rd_valid;
  endproperty
  property p_wr;
    wr_take |-> !cs_n && !sclk && io_oe == 4'hF;
  endproperty
  property p_gap;
    $rose(cs_n) |-> (cs_n && busy)[*2];
  endproperty
  property p_exit;
    !quad_active |-> !cmd_ready;
  endproperty
  property p_ready;
    $fell(busy) && quad_active |=> cmd_ready || !quad_active;
  endproperty
  property p_frame;
    $fell(cs_n) |-> !cs_n[*8] ##[1:400] cs_n;
  endproperty
  a_take: assert property (p_take)
    else $error("frame did not open with opcode high nibble");
  a_idle: assert property (p_idle)
    else $error("sclk high outside a frame");
  a_lanes: assert property (p_lanes)
    else $error("lanes moved off an sclk fall");
  a_rd: assert property (p_rd)
    else $error("read byte while lanes driven or pulse too long");
  a_wr: assert property (p_wr)
    else $error("write byte taken outside a driven frame");
  a_gap: assert property (p_gap)
    else $error("chip select gap too short");
  a_exit: assert property (p_exit)
    else $error("command accepted after leaving four-lane mode");
  a_ready: assert property (p_ready)
    else $error("ready did not return after busy");
  a_frame: assert property (p_frame)
    else $error("frame length out of range");
  c_rd: cover property (rd_valid);
  c_wr: cover property (wr_take);
  c_exit: cover property (!quad_active);
endmodule
bind qpi_host qpi_host_props u_props (.ref_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op,
  .wr_take, .rd_valid, .busy, .quad_active, .sclk, .cs_n, .io_out, .io_oe);
`default_nettype wire

// [qpi_host_tb.sv]
// Self-checking bench for the four-lane flash host against the flash model.
// Assumes qpi_host, its checker and the flash model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module qpi_host_tb;
  localparam logic [23:0] JID = 24'h3C_4117;
  localparam logic [7:0] EID = 8'h2B;
  logic ref_clk = 0, rst_n = 0, cmd_valid = 0, cmd_ready, wr_take, rd_valid, busy;
  logic quad_active, sclk, cs_n, fl_en;
  logic [7:0] cmd_op = 0, wr_data = 0, rd_data, b0, b1, b2;
  logic [23:0] cmd_addr = 0, a;
  logic [11:0] cmd_len = 0;
  logic [1:0] read_wrap;
  logic [3:0] io_out, io_oe, io_in, fl_drv, junk = 4'h5;
  logic [7:0] wq[4], rq[$];
  logic [7:0] ops[3] = '{8'h0B, 8'h0C, 8'hEB};
  int errors = 0, samples_checked = 0, cyc = 0, nibs = 0, takes = 0, edc = 1, n;
  // Released lanes show a pattern that changes every cycle
  assign io_in = (io_oe != 0) ? io_out : fl_en ? fl_drv : junk;
  qpi_host #(.SCLK_HALF(2), .LEN_W(12)) uut (.ref_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_len, .wr_data, .wr_take, .rd_data, .rd_valid, .busy, .quad_active,
    .read_wrap, .sclk, .cs_n, .io_out, .io_oe, .io_in);
  qpi_flash_model #(.JID(JID), .EID(EID)) flash (.sclk, .cs_n, .io(io_in), .drv(fl_drv),
    .en(fl_en));
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) junk <= ~junk;
  always @(posedge sclk) nibs <= cs_n ? nibs : nibs + 1;
  always @(negedge ref_clk) begin
    cyc++;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_take === 1'b1) begin
      takes++;
      wr_data <= wq[takes % 4];
    end
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [23:0] ad, input int len, input int nb);
    int d;
    d = (op inside {8'h0B, 8'h0C, 8'hEB, 8'h5A}) ? (edc == 0 ? 10 : 2 * edc + 2) : 0;
    if (op inside {8'h0B, 8'h0C, 8'hEB, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h3D, 8'h90,
        8'h5A}
        || (op == 8'hAB && len > 0)) d += 6;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    rq.delete();
    takes = 0;
    nibs = 0;
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_len = len[11:0];
    wr_data = wq[0];
    @(negedge ref_clk);
    cmd_valid = 0;
    while (busy !== 1'b0) @(negedge ref_clk);
    `CHK(nibs, 2 + d + 2 * nb)
    `CHK(rq.size() + takes, nb)
  endtask
  task automatic rd1(input logic [7:0] op, input logic [7:0] e);
    run(op, 24'h00_0000, 1, 1);
    `CHK(rq[0], e)
  endtask
  initial begin
    n = $urandom(32'h483e);
    repeat (6) @(negedge ref_clk);
    rst_n = 1;
    run(8'h9F, 0, 5, 3);
    `CHK({rq[0], rq[1], rq[2]}, JID)
    rd1(8'h05, 8'h00);
    run(8'h06, 0, 0, 0);
    rd1(8'h05, 8'h02);
    run(8'h04, 0, 0, 0);
    rd1(8'h05, 8'h00);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    wq = '{b0, b1, b2, b0};
    run(8'h06, 0, 0, 0);
    run(8'h01, 0, 2, 2);
    rd1(8'h05, {b0[7:2], 2'b00});
    rd1(8'h35, b1);
    wq[0] = b2;
    run(8'h06, 0, 0, 0);
    run(8'h31, 0, 1, 1);
    rd1(8'h35, b2);
    rd1(8'h05, {b0[7:2], 2'b00});
    wq[0] = ~b2;
    run(8'h50, 0, 0, 0);
    run(8'h11, 0, 1, 1);
    rd1(8'h15, ~b2);
    run(8'h7E, 0, 0, 0);
    rd1(8'h3D, 8'h01);
    run(8'h98, 0, 0, 0);
    rd1(8'h3D, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wq[0] = {2'b00, 2'(c), 2'b00, 2'($urandom)};
      run(8'hC0, 0, 1, 1);
      edc = c;
      `CHK(read_wrap, wq[0][1:0])
      for (int o = 0; o < 3; o++) begin
        a = 24'($urandom);
        n = 1 + $urandom % 4;
        run(ops[o], a, n, n);
        for (int k = 0; k < n; k++) `CHK(rq[k], a[7:0] + 8'(k))
      end
    end
    a = 24'($urandom);
    run(8'h5A, a, 1, 1);
    `CHK(rq[0], a[7:0])
    run(8'h90, 0, 2, 2);
    `CHK({rq[0], rq[1]}, JID[23:8])
    foreach (wq[i]) wq[i] = 8'($urandom);
    run(8'h02, 24'($urandom), 3, 3);
    `CHK({flash.b0, flash.b1}, {wq[0], wq[1]})
    for (int i = 0; i < 9; i++) begin
      b0 = i < 3 ? 8'h20 + 8'h32 * 8'(i) + 8'(i / 2) * 8'h54 : 8'h00;
      run(i == 0 ? 8'h20 : i == 1 ? 8'h52 : i == 2 ? 8'hD8 : i == 3 ? 8'h60 : i == 4 ? 8'hC7
        : i == 5 ? 8'h75 : i == 6 ? 8'h7A : i == 7 ? 8'h36 : 8'h39, 24'($urandom), 0, 0);
    end
    run(8'hB9, 0, 0, 0);
    run(8'hAB, 24'($urandom), 1, 1);
    `CHK(rq[0], EID)
    run(8'hAB, 0, 0, 0);
    wq[0] = 8'h30;
    run(8'hC0, 0, 1, 1);
    edc = 3;
    run(8'h66, 0, 0, 0);
    run(8'h99, 0, 0, 0);
    edc = 1;
    a = 24'($urandom);
    run(8'h0B, a, 2, 2);
    `CHK({rq[0], rq[1]}, {a[7:0], a[7:0] + 8'h01})
    run(8'hFF, 0, 0, 0);
    repeat (4) @(negedge ref_clk);
    `CHK(quad_active, 1'b0)
    `CHK(cmd_ready, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
